// ===== inc/afp_pkg.sv
package afp_pkg;

  // fifo geometry
  localparam int unsigned AFP_DEPTH = 64;
  localparam int unsigned AFP_WORD_W = 18;
  localparam int unsigned AFP_MARGIN_W = 5;
  localparam int unsigned AFP_CNT_W = 7;

  // margin used until the pins program one
  localparam logic [4:0] AFP_MARGIN_RST = 5'h08;

  // register byte offsets on the axi4-lite port
  localparam logic [3:0] AFP_OFS_STATUS = 4'h0;
  localparam logic [3:0] AFP_OFS_MASK = 4'h4;
  localparam logic [3:0] AFP_OFS_MARGIN = 4'h8;
  localparam logic [3:0] AFP_OFS_COUNT = 4'hc;

  // status and mask bit positions
  localparam int unsigned AFP_EV_PROG = 0;
  localparam int unsigned AFP_EV_CLOSE = 1;
  localparam int unsigned AFP_EV_ALMOST = 2;
  localparam int unsigned AFP_EV_W = 3;

  // margin register field positions
  localparam int unsigned AFP_FLD_EMPTY = 0;
  localparam int unsigned AFP_FLD_FULL = 8;
  localparam int unsigned AFP_FLD_CLOSED = 16;

  // axi response codes
  localparam logic [1:0] AFP_RESP_OKAY = 2'h0;
  localparam logic [1:0] AFP_RESP_SLVERR = 2'h2;

  // offset programming sequence
  typedef enum logic [1:0] {
    AFP_PRG_OPEN = 2'b00,
    AFP_PRG_FIRST = 2'b01,
    AFP_PRG_CLOSED = 2'b10
  } afp_prg_state_t;

  // the two margins travel together
  typedef struct packed {
    logic [4:0] full;
    logic [4:0] empty;
  } afp_margin_t;

endpackage

// ===== hdl/afp_offset_prog.sv
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module afp_offset_prog
  import afp_pkg::*;
#(
  parameter int unsigned DEPTH = AFP_DEPTH,
  parameter int unsigned WORD_W = AFP_WORD_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // writer pins
  input wire logic offset_program_enable_n,
  input wire logic write_enable_hi,
  input wire logic write_enable_lo_n,
  input wire logic [WORD_W-1:0] input_word,
  // read side removes one word
  input wire logic read_taken,
  // flags and memory store port
  output logic input_ready,
  output logic almost_bound_flag,
  output logic store_en,
  output logic [WORD_W-1:0] store_word,
  output logic [AFP_CNT_W-1:0] occupancy,
  // interrupt
  output logic irq,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // the counter and margin compare are sized for the documented 64 words
  if (DEPTH != AFP_DEPTH || WORD_W < AFP_MARGIN_W)
  begin : g_bad_param
    $error("afp_offset_prog: unsupported depth or word width");
  end

  // ready rises two edges after reset release
  logic [1:0] up_ff;
  // programming sequence state
  afp_prg_state_t prg_ff, nxt_prg;
  // current margins
  afp_margin_t margin_ff, nxt_margin;
  // occupancy
  logic [AFP_CNT_W-1:0] cnt_ff, nxt_cnt;
  // registered flag and store outputs
  logic almost_ff, nxt_almost;
  logic store_ff;
  logic [WORD_W-1:0] word_ff;
  // interrupt status and mask
  logic [AFP_EV_W-1:0] status_ff, nxt_status, mask_ff, nxt_mask;
  // axi slave state
  logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // full when the count reaches depth
  wire not_full = (cnt_ff != AFP_CNT_W'(DEPTH));
  // pins ask for programming and the window is still open
  wire prog_active = !offset_program_enable_n && (prg_ff != AFP_PRG_CLOSED);
  wire store_go = write_enable_hi && !write_enable_lo_n && input_ready
                  && !prog_active;
  wire read_go = read_taken && (cnt_ff != '0);
  wire prog_evt = prog_active;
  wire close_evt = store_go && (prg_ff != AFP_PRG_CLOSED);

  // threshold compare, shared by flag and its event
  function automatic logic almost_hit(input logic [AFP_CNT_W-1:0] c, input afp_margin_t m);
    almost_hit = (c <= {2'b00, m.empty})
                 || (c >= AFP_CNT_W'(DEPTH) - {2'b00, m.full});
  endfunction

  assign input_ready = up_ff[1] && not_full;
  assign store_en = store_ff;
  assign store_word = word_ff;
  assign occupancy = cnt_ff;
  assign almost_bound_flag = almost_ff;

  // programming sequence: first edge loads both, held edges reload full only
  always_comb
  begin
    nxt_prg = prg_ff;
    nxt_margin = margin_ff;
    case (prg_ff)
      AFP_PRG_OPEN:
      begin
        if (!offset_program_enable_n)
        begin
          nxt_margin.empty = input_word[AFP_MARGIN_W-1:0];
          nxt_margin.full = input_word[AFP_MARGIN_W-1:0];
          nxt_prg = AFP_PRG_FIRST;
        end
        else if (store_go)
          nxt_prg = AFP_PRG_CLOSED;
      end
      AFP_PRG_FIRST:
      begin
        if (!offset_program_enable_n)
          nxt_margin.full = input_word[AFP_MARGIN_W-1:0];
        else if (store_go)
          nxt_prg = AFP_PRG_CLOSED;
        else
          nxt_prg = AFP_PRG_OPEN;
      end
      AFP_PRG_CLOSED:
        nxt_prg = AFP_PRG_CLOSED; // pins ignored from now on
      default:
        nxt_prg = AFP_PRG_OPEN;
    endcase
  end

  // occupancy and flag, both domains folded onto one clock
  always_comb
  begin
    nxt_cnt = cnt_ff + AFP_CNT_W'(store_go) - AFP_CNT_W'(read_go);
    nxt_almost = almost_hit(nxt_cnt, nxt_margin);
  end

  // interrupt events; set wins over the read clear
  wire st_rd = s_axi_arvalid && s_axi_arready && (s_axi_araddr == AFP_OFS_STATUS);
  wire [AFP_EV_W-1:0] ev_set = {nxt_almost && !almost_ff, close_evt, prog_evt};
  always_comb
  begin
    nxt_status = (st_rd ? '0 : status_ff) | ev_set;
  end
  assign irq = |(status_ff & mask_ff);

  // reset release tracking
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      up_ff <= 2'b00;
    else
      up_ff <= {up_ff[0], 1'b1};
  end

  // programming state and margins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prg_ff <= AFP_PRG_OPEN;
      margin_ff <= '{full: AFP_MARGIN_RST, empty: AFP_MARGIN_RST};
    end
    else
    begin
      prg_ff <= nxt_prg;
      margin_ff <= nxt_margin;
    end
  end

  // count, flag and store outputs
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff <= '0;
      almost_ff <= 1'b1;
      store_ff <= 1'b0;
      word_ff <= '0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      almost_ff <= nxt_almost;
      store_ff <= store_go;
      word_ff <= input_word;
    end
  end

  // write decode: both halves held, then answered together
  wire wr_fire = aw_hold_ff && w_hold_ff && !bvalid_ff;
  wire wr_mask = wr_fire && (awaddr_ff == AFP_OFS_MASK);
  wire wr_ok = wr_mask || (awaddr_ff == AFP_OFS_STATUS) || (awaddr_ff == AFP_OFS_MARGIN)
               || (awaddr_ff == AFP_OFS_COUNT);
  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr_mask && wstrb_ff[0])
      nxt_mask = wdata_ff[AFP_EV_W-1:0];
  end
  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready = !w_hold_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // read decode; unmapped answers slverr with zero data
  wire [31:0] rd_margin = (32'(margin_ff.empty) << AFP_FLD_EMPTY)
                          | (32'(margin_ff.full) << AFP_FLD_FULL)
                          | (32'(prg_ff == AFP_PRG_CLOSED) << AFP_FLD_CLOSED);
  wire [31:0] rd_mux = (s_axi_araddr == AFP_OFS_STATUS) ? 32'(status_ff) :
                       (s_axi_araddr == AFP_OFS_MASK) ? 32'(mask_ff) :
                       (s_axi_araddr == AFP_OFS_MARGIN) ? rd_margin :
                       (s_axi_araddr == AFP_OFS_COUNT) ? 32'(cnt_ff) : 32'h0000_0000;
  wire rd_hit = (s_axi_araddr == AFP_OFS_STATUS) || (s_axi_araddr == AFP_OFS_MASK)
                || (s_axi_araddr == AFP_OFS_MARGIN) || (s_axi_araddr == AFP_OFS_COUNT);
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // write channel holding registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_ff)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[3:2], 2'b00};
      end
      else if (wr_fire)
        aw_hold_ff <= 1'b0;
      if (s_axi_wvalid && !w_hold_ff)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_hold_ff <= 1'b0;
    end
  end

  // write response and read data
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= AFP_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= AFP_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? AFP_RESP_OKAY : AFP_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
      if (s_axi_arvalid && !rvalid_ff)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? AFP_RESP_OKAY : AFP_RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  // interrupt registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_ff <= '0;
      mask_ff <= '0;
    end
    else
    begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
    end
  end

  // helper: margins were ever loaded since reset
  logic loaded_ff;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      loaded_ff <= 1'b0;
    else if (prog_active)
      loaded_ff <= 1'b1;
  end

  a_default_margin: assert property (@(posedge clk) disable iff (!rstn)
    !loaded_ff |-> margin_ff.empty == 5'h08 && margin_ff.full == 5'h08)
    else $error("margins left their default without programming");
  a_flag_threshold: assert property (@(posedge clk) disable iff (!rstn)
    almost_bound_flag == ((cnt_ff <= {2'b00, margin_ff.empty})
                          || (cnt_ff >= 7'h40 - {2'b00, margin_ff.full})))
    else $error("almost flag disagrees with count and margins");
  a_first_capture: assert property (@(posedge clk) disable iff (!rstn)
    (prg_ff == AFP_PRG_OPEN && !offset_program_enable_n)
    |=> margin_ff.empty == $past(input_word[4:0]) && margin_ff.full == $past(input_word[4:0]))
    else $error("first program edge did not load both margins");
  a_second_capture: assert property (@(posedge clk) disable iff (!rstn)
    (prg_ff == AFP_PRG_FIRST && !offset_program_enable_n)
    |=> margin_ff.full == $past(input_word[4:0]) && $stable(margin_ff.empty))
    else $error("held program edge did not reload only the full margin");
  a_no_store_prog: assert property (@(posedge clk) disable iff (!rstn)
    prog_active |=> !store_en)
    else $error("word stored during margin programming");
  a_store_cond: assert property (@(posedge clk) disable iff (!rstn)
    store_en |-> $past(write_enable_hi) && !$past(write_enable_lo_n) && $past(input_ready))
    else $error("word stored without enables and ready");
  a_ready_rise: assert property (@(posedge clk) disable iff (!rstn)
    $rose(up_ff[1]) |-> $past(up_ff[0]) && input_ready == (cnt_ff != 7'h40))
    else $error("input ready did not follow reset release timing");
  a_count_track: assert property (@(posedge clk) disable iff (!rstn)
    ##1 cnt_ff == $past(cnt_ff) + 7'($past(store_go)) - 7'($past(read_go)))
    else $error("occupancy count lost a write or read");
  a_closed_hold: assert property (@(posedge clk) disable iff (!rstn)
    (prg_ff == AFP_PRG_CLOSED) |=> $stable(margin_ff) && prg_ff == AFP_PRG_CLOSED)
    else $error("margins changed after the first stored word");
  a_open_window: assert property (@(posedge clk) disable iff (!rstn)
    (margin_ff != $past(margin_ff)) |-> $past(prg_ff) != AFP_PRG_CLOSED)
    else $error("margins accepted outside the programming window");

endmodule // afp_offset_prog

// ===== dv/afp_writer.sv
`timescale 1ns/10ps
// writer and read-side stand-in at the fifo pins
module afp_writer
(
  // clock and ready flag
  input wire logic clk,
  input wire logic input_ready,
  // pins toward the block
  output logic offset_program_enable_n,
  output logic write_enable_hi,
  output logic write_enable_lo_n,
  output logic [17:0] input_word,
  output logic read_taken
);
  // program enable idles high so the default margins hold
  initial
  begin
    offset_program_enable_n = 1'b1;
    write_enable_hi = 1'b0;
    write_enable_lo_n = 1'b1;
    input_word = 18'h0;
    read_taken = 1'b0;
  end

  // one write attempt; en low leaves the high enable off
  task automatic put(input logic [17:0] w, input logic en);
    @(posedge clk);
    write_enable_hi <= en;
    write_enable_lo_n <= 1'b0;
    input_word <= w;
    @(posedge clk);
    write_enable_hi <= 1'b0;
    write_enable_lo_n <= 1'b1;
    // released bus shows no stale word
    input_word <= ~w;
  endtask

  // margin load; two holds the enable over a second edge
  task automatic prog(input logic [4:0] a, input logic [4:0] b, input logic two, input logic we);
    logic ok;
    @(negedge clk);
    ok = input_ready;
    @(posedge clk);
    // only lowered while ready is seen high
    if (ok)
    begin
      offset_program_enable_n <= 1'b0;
      input_word <= {13'h0, a};
      write_enable_hi <= we;
      write_enable_lo_n <= ~we;
      @(posedge clk);
      // the second value only goes out when the enable is held over it
      if (two)
      begin
        input_word <= {13'h0, b};
        @(posedge clk);
      end
      offset_program_enable_n <= 1'b1;
      write_enable_hi <= 1'b0;
      write_enable_lo_n <= 1'b1;
      input_word <= ~input_word;
    end
  endtask

  // read side removes one word
  task automatic take();
    @(posedge clk);
    read_taken <= 1'b1;
    @(posedge clk);
    read_taken <= 1'b0;
  endtask
endmodule // afp_writer

// ===== dv/tb_fifo_almost_flag_offset_prog.sv
`timescale 1ns/10ps
module tb_fifo_almost_flag_offset_prog
  import afp_pkg::*;
;
  // pins and bus
  logic clk, rstn, offset_program_enable_n, write_enable_hi, write_enable_lo_n, read_taken;
  logic input_ready, almost_bound_flag, store_en, irq;
  logic [17:0] input_word, store_word;
  logic [6:0] occupancy;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // model state: margins, count, sticky status, mask
  int err_count, tests_run, cyc, stores, nst, em, fm, cnt, st, msk;
  logic closed;
  // words expected at the store port, oldest first
  logic [17:0] wq[$];

  afp_offset_prog i_dut (.clk, .rstn, .offset_program_enable_n, .write_enable_hi,
    .write_enable_lo_n, .input_word, .read_taken, .input_ready, .almost_bound_flag, .store_en,
    .store_word, .occupancy, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  afp_writer i_wr (.clk, .input_ready, .offset_program_enable_n, .write_enable_hi,
    .write_enable_lo_n, .input_word, .read_taken);

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // store pulses seen and hang limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (store_en === 1'b1)
    begin
      stores <= stores + 1;
      if (wq.size() > 0)
        cword({14'h0, store_word}, {14'h0, wq.pop_front()});
    end
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  function automatic logic flag_exp();
    return (cnt <= em) || (cnt >= 64 - fm);
  endfunction

  function automatic logic [31:0] mreg();
    return {15'h0, closed, 3'h0, 5'(fm), 3'h0, 5'(em)};
  endfunction

  task automatic cbit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cword(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    logic da, dw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw))
    begin
      @(negedge clk);
      if (s_axi_awvalid & s_axi_awready)
        da = 1'b1;
      if (s_axi_wvalid & s_axi_wready)
        dw = 1'b1;
      @(posedge clk);
      if (da)
        s_axi_awvalid <= 1'b0;
      if (dw)
        s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    cword({30'h0, s_axi_bresp}, {30'h0, AFP_RESP_OKAY});
    @(posedge clk);
    s_axi_bready <= 1'b0;
    msk = v & 7;
  endtask

  // read one register and compare data and response
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    cword(s_axi_rdata, e);
    cword({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic cstate();
    cword({25'h0, occupancy}, cnt);
    cbit(almost_bound_flag, flag_exp());
    cbit(input_ready, cnt < 64);
  endtask

  // interrupt follows masked status; reading clears it
  task automatic stchk();
    cbit(irq, (st & msk) != 0);
    rchk(AFP_OFS_STATUS, st, AFP_RESP_OKAY);
    st = 0;
    #1;
    cbit(irq, 1'b0);
  endtask

  // kind 0 write with high enable off, 1 write, 2 read
  task automatic step(input int kind);
    logic f0;
    logic [17:0] w;
    f0 = flag_exp();
    w = 18'($urandom);
    if (kind == 2)
      i_wr.take();
    else
      i_wr.put(w, kind == 1);
    #1;
    if (kind == 2 && cnt > 0)
      cnt--;
    if (kind == 1 && cnt < 64)
    begin
      cnt++;
      nst++;
      wq.push_back(w);
      if (!closed)
        st |= 1 << AFP_EV_CLOSE;
      closed = 1'b1;
    end
    if (!f0 && flag_exp())
      st |= 1 << AFP_EV_ALMOST;
    cstate();
  endtask

  // random margins; model ignores them once closed
  task automatic pg(input logic two, input logic we);
    logic [4:0] a, b;
    a = 5'($urandom);
    b = 5'($urandom);
    i_wr.prog(a, b, two, we);
    if (!closed)
    begin
      em = a;
      fm = two ? b : a;
      st |= 1 << AFP_EV_PROG;
    end
  endtask

  task automatic rst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (6) @(posedge clk);
    cbit(almost_bound_flag, 1'b1);
    cbit(input_ready, 1'b0);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    cbit(input_ready, 1'b0);
    @(posedge clk);
    #1;
    cbit(input_ready, 1'b1);
    em = 8;
    fm = 8;
    cnt = 0;
    st = 0;
    msk = 0;
    closed = 1'b0;
    wq.delete();
  endtask

  task automatic final_report();
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h0, 32'h0, 4'hf};
    {err_count, tests_run, nst} = {3{32'h0}};
    void'($urandom(44110));
    rst();
    rchk(AFP_OFS_MASK, 32'h0, AFP_RESP_OKAY);
    rchk(AFP_OFS_MARGIN, mreg(), AFP_RESP_OKAY);
    rchk(4'h2, 32'h0, AFP_RESP_SLVERR);
    pg(1'b1, 1'b1);
    rchk(AFP_OFS_MARGIN, mreg(), AFP_RESP_OKAY);
    pg(1'b0, 1'b1);
    rchk(AFP_OFS_MARGIN, mreg(), AFP_RESP_OKAY);
    cstate();
    axw(AFP_OFS_MASK, 32'h7);
    rchk(AFP_OFS_MASK, 32'h7, AFP_RESP_OKAY);
    stchk();
    repeat (30) step($urandom_range(0, 1));
    pg(1'b1, 1'b0);
    rchk(AFP_OFS_MARGIN, mreg(), AFP_RESP_OKAY);
    axw(AFP_OFS_MASK, 32'h0);
    stchk();
    axw(AFP_OFS_MASK, 32'h7);
    while (cnt < 64) step(1);
    step(1);
    rchk(AFP_OFS_COUNT, cnt, AFP_RESP_OKAY);
    stchk();
    repeat (66) step(2);
    stchk();
    cword(stores, nst);
    rst();
    pg(1'b0, 1'b1);
    rchk(AFP_OFS_MARGIN, mreg(), AFP_RESP_OKAY);
    final_report();
  end
endmodule // tb_fifo_almost_flag_offset_prog
